// *** src/trng_gate_defines.svh ***
// constants for the random number output stage
// assumes inclusion by the package and the design file only
`ifndef TRNG_GATE_DEFINES_SVH
`define TRNG_GATE_DEFINES_SVH
`define TF_RUN_LEN 16
`define WIN_LEN 256
`define WIN_LO 96
`define WIN_HI 160
`define STARTUP_WINDOWS 2
`define REQ_W 33
`endif

// *** src/trng_gate_pkg.sv ***
// types for the random number output stage
// assumes the defines header sits beside this file
`include "trng_gate_defines.svh"
package trng_gate_pkg;
    typedef struct packed {
        logic wide;
        logic [`REQ_W-1:0] nbytes;
    } req_t;
    typedef struct packed {
        logic [15:0] data;
        logic last;
    } word_t;
endpackage : trng_gate_pkg

// *** src/trng_health_gated_output.sv ***
// random word output stage gated by total-failure and online tests
// assumes raw bits arrive with raw_valid, synchronous to clk
//
// Function
// - total-failure check from start; failure releases nothing
// - failure blocks words built from bits after the failure
// - online statistical test at start and throughout operation
// - no output until start test passes or after any defect
// - online test runs continuously on fixed windows
// - words are delivered 8 or 16 bits wide
// - library request of n bytes, multiple of four, returns exactly n
// - entropy quality depends on source; tests reject bad windows
`timescale 1ns/1ps
`include "trng_gate_defines.svh"
module trng_health_gated_output #(
    parameter int TF_RUN = `TF_RUN_LEN,
    parameter int WIN = `WIN_LEN,
    parameter int LO = `WIN_LO,
    parameter int HI = `WIN_HI
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic raw_bit,
    input wire logic raw_valid,
    input wire logic word_wide,
    input wire logic word_ready,
    output logic word_valid,
    output logic [15:0] word_data,
    input wire logic req_valid,
    input wire trng_gate_pkg::req_t req,
    output logic req_ready,
    output logic req_error,
    output trng_gate_pkg::word_t lib_word,
    output logic lib_valid,
    input wire logic lib_ready,
    output logic fail_sticky,
    output logic healthy
);
    import trng_gate_pkg::*;

    // ----------------------------------------------------------------
    // health tests
    // ----------------------------------------------------------------
    logic prev_ff, nxt_prev;
    logic [7:0] run_ff, nxt_run;
    logic [8:0] cnt_ff, nxt_cnt;
    logic [8:0] ones_ff, nxt_ones;
    logic [1:0] good_ff, nxt_good;
    logic ok_ff, nxt_ok;
    logic fail_ff, nxt_fail;
    logic tf_hit, win_end, win_bad;

    always_comb begin
        nxt_prev = prev_ff;
        nxt_run = run_ff;
        nxt_cnt = cnt_ff;
        nxt_ones = ones_ff;
        nxt_good = good_ff;
        nxt_ok = ok_ff;
        nxt_fail = fail_ff;
        tf_hit = 1'b0;
        win_end = 1'b0;
        win_bad = 1'b0;
        if (raw_valid) begin
            nxt_prev = raw_bit;
            nxt_run = (raw_bit == prev_ff) ? run_ff + 8'h01 : 8'h01;
            // stuck source: long constant run counts as total failure
            tf_hit = (raw_bit == prev_ff) &&
                     (run_ff >= 8'(TF_RUN - 1));
            nxt_ones = ones_ff + {8'h00, raw_bit};
            nxt_cnt = cnt_ff + 9'h001;
            if (cnt_ff == 9'(WIN - 1)) begin
                win_end = 1'b1;
                win_bad = (nxt_ones < 9'(LO)) ||
                          (nxt_ones > 9'(HI));
                nxt_cnt = 9'h000;
                nxt_ones = 9'h000;
                if (!win_bad && good_ff != 2'(`STARTUP_WINDOWS))
                    nxt_good = good_ff + 2'h1;
                if (!win_bad && good_ff == 2'(`STARTUP_WINDOWS - 1))
                    nxt_ok = 1'b1;
            end
        end
        // failure latches until reset; restart is the only recovery
        if (tf_hit || win_bad) begin
            nxt_fail = 1'b1;
            nxt_ok = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_ff <= 1'b0;
            run_ff <= 8'h00;
            cnt_ff <= 9'h000;
            ones_ff <= 9'h000;
            good_ff <= 2'h0;
            ok_ff <= 1'b0;
            fail_ff <= 1'b0;
        end else begin
            prev_ff <= nxt_prev;
            run_ff <= nxt_run;
            cnt_ff <= nxt_cnt;
            ones_ff <= nxt_ones;
            good_ff <= nxt_good;
            ok_ff <= nxt_ok;
            fail_ff <= nxt_fail;
        end
    end

    logic pass;
    assign pass = ok_ff && !fail_ff && !tf_hit && !win_bad;
    assign healthy = pass;
    assign fail_sticky = fail_ff;

    // ----------------------------------------------------------------
    // word assembly
    // ----------------------------------------------------------------
    logic [15:0] sh_ff, nxt_sh;
    logic [4:0] nb_ff, nxt_nb;
    logic [15:0] out_ff, nxt_out;
    logic oval_ff, nxt_oval;
    logic wid_ff, nxt_wid;
    logic owid_ff, nxt_owid;
    logic lib_sel, lib_start, lib_end;
    logic [4:0] need;
    logic take;

    // a word leaves only through the handshake of the path that owns it
    assign take = (word_valid && word_ready) || (lib_valid && lib_ready);
    assign need = wid_ff ? 5'h10 : 5'h08;

    always_comb begin
        nxt_sh = sh_ff;
        nxt_nb = nb_ff;
        nxt_out = out_ff;
        nxt_oval = oval_ff;
        nxt_wid = wid_ff;
        nxt_owid = owid_ff;
        if (take)
            nxt_oval = 1'b0;
        if (raw_valid) begin
            nxt_sh = {sh_ff[14:0], raw_bit};
            // saturate so a stalled consumer cannot wrap the count
            if (nb_ff < need)
                nxt_nb = nb_ff + 5'h01;
        end
        if (nb_ff >= need && (!oval_ff || take)) begin
            // no word is built in a cycle where pass is low
            if (pass) begin
                nxt_out = wid_ff ? sh_ff : {8'h00, sh_ff[7:0]};
                nxt_owid = wid_ff;
                nxt_oval = 1'b1;
            end
            nxt_nb = {4'h0, raw_valid};
            nxt_wid = lib_sel ? 1'b1 : word_wide;
        end
        // a request boundary drops any waiting or half-built word, so
        // library words are full 16-bit and direct words follow word_wide
        if (lib_start || lib_end) begin
            nxt_oval = 1'b0;
            nxt_nb = 5'h00;
            nxt_wid = lib_start ? 1'b1 : word_wide;
        end
        if (!pass) begin
            nxt_oval = 1'b0;
            nxt_nb = 5'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sh_ff <= 16'h0000;
            nb_ff <= 5'h00;
            out_ff <= 16'h0000;
            oval_ff <= 1'b0;
            wid_ff <= 1'b0;
            owid_ff <= 1'b0;
        end else begin
            sh_ff <= nxt_sh;
            nb_ff <= nxt_nb;
            out_ff <= nxt_out;
            oval_ff <= nxt_oval;
            wid_ff <= nxt_wid;
            owid_ff <= nxt_owid;
        end
    end

    assign word_valid = oval_ff && pass && !lib_sel;
    assign word_data = out_ff;

    // ----------------------------------------------------------------
    // library byte requests, served two bytes per word
    // ----------------------------------------------------------------
    logic [`REQ_W-1:0] left_ff, nxt_left;
    logic busy_ff, nxt_busy;
    logic err_ff, nxt_err;
    logic [`REQ_W-1:0] max_n;

    assign max_n = {1'b1, {(`REQ_W-1){1'b0}}};
    assign lib_sel = busy_ff;
    assign req_ready = !busy_ff;
    assign lib_valid = busy_ff && oval_ff && pass;

    always_comb begin
        nxt_left = left_ff;
        nxt_busy = busy_ff;
        nxt_err = 1'b0;
        lib_start = 1'b0;
        lib_end = 1'b0;
        if (!busy_ff && req_valid) begin
            if (req.nbytes[1:0] != 2'h0 || req.nbytes > max_n)
                nxt_err = 1'b1;
            else if (req.nbytes != '0) begin
                nxt_left = req.nbytes;
                nxt_busy = 1'b1;
                lib_start = 1'b1;
            end
        end
        if (lib_valid && lib_ready) begin
            nxt_left = left_ff - `REQ_W'(2);
            if (left_ff == `REQ_W'(2))
                nxt_busy = 1'b0;
            if (left_ff == `REQ_W'(2))
                lib_end = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            left_ff <= '0;
            busy_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            left_ff <= nxt_left;
            busy_ff <= nxt_busy;
            err_ff <= nxt_err;
        end
    end

    assign req_error = err_ff;
    assign lib_word = {out_ff, (left_ff == `REQ_W'(2))};

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_fail;
        fail_ff;
    endsequence

    chk_no_out_fail: assert property (@(posedge clk) disable iff (rst)
        s_fail |-> !word_valid && !lib_valid)
        else $error("output while failed");
    chk_stuck_flag: assert property (@(posedge clk) disable iff (rst)
        tf_hit |=> fail_ff)
        else $error("stuck run not flagged");
    chk_window_flag: assert property (@(posedge clk) disable iff (rst)
        win_bad |=> fail_sticky && !healthy)
        else $error("bad window not flagged");
    chk_startup_gate: assert property (@(posedge clk) disable iff (rst)
        !ok_ff |-> !word_valid)
        else $error("output before startup pass");
    chk_window_wrap: assert property (@(posedge clk) disable iff (rst)
        raw_valid && cnt_ff == 9'(WIN - 1) |=> cnt_ff == 9'h000)
        else $error("window length wrong");
    chk_narrow_word: assert property (@(posedge clk) disable iff (rst)
        word_valid && !owid_ff |-> word_data[15:8] == 8'h00)
        else $error("narrow word upper bits set");
    chk_lib_count: assert property (@(posedge clk) disable iff (rst)
        lib_valid && lib_ready && lib_word.last |=> !busy_ff)
        else $error("request did not end");
    chk_sticky_hold: assert property (@(posedge clk) disable iff (rst)
        fail_sticky |=> fail_sticky)
        else $error("failure flag dropped");
    chk_bad_req: assert property (@(posedge clk) disable iff (rst)
        !busy_ff && req_valid && req.nbytes[1:0] != 2'h0
        |=> req_error && !busy_ff)
        else $error("odd request accepted");
    chk_stuck_block: assert property (@(posedge clk) disable iff (rst)
        tf_hit |-> !word_valid && !lib_valid)
        else $error("word shown on stuck bit");
    chk_lib_width: assert property (@(posedge clk) disable iff (rst)
        lib_valid |-> owid_ff)
        else $error("library word not 16-bit");
endmodule : trng_health_gated_output

// *** dv/word_sink.sv ***
// consumer standing in for the processor that takes random words
// assumes the block's clk and rst; stalls in an eight-cycle pattern set by duty
`timescale 1ns/1ps
module word_sink (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] duty,
    output logic ready
);
    logic [2:0] cnt_ff;
    logic ready_ff;
    // stalls force valid to stand across idle cycles
    always_ff @(posedge clk) begin
        cnt_ff <= rst ? 3'h0 : cnt_ff + 3'h1;
        ready_ff <= !rst && (cnt_ff < duty);
    end
    assign ready = ready_ff;
endmodule : word_sink

// *** dv/tb_trng_health_gated_output.sv ***
// self-checking bench for the gated random word output stage
// assumes the package and design under src/; short test windows
`timescale 1ns/1ps
module tb_trng_health_gated_output;
    import trng_gate_pkg::*;
    logic clk, rst, raw_bit, raw_valid, word_wide, word_ready, word_valid;
    logic req_valid, req_ready, req_error, lib_valid, lib_ready;
    logic fail_sticky, healthy, err_seen, narrow;
    logic [15:0] word_data;
    logic [7:0] lf;
    req_t req;
    word_t lib_word;
    int errors = 0, samples_checked = 0, mode = 0;
    int ones, nb, good, dw, lw, last_at, pc, mrun;
    logic mprev, mfail;
    trng_health_gated_output #(.TF_RUN(8), .WIN(16), .LO(4), .HI(12))
        trng_health_gated_output_inst (.clk(clk), .rst(rst),
        .raw_bit(raw_bit), .raw_valid(raw_valid), .word_wide(word_wide),
        .word_ready(word_ready), .word_valid(word_valid),
        .word_data(word_data), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .req_error(req_error), .lib_word(lib_word),
        .lib_valid(lib_valid), .lib_ready(lib_ready),
        .fail_sticky(fail_sticky), .healthy(healthy));
    word_sink word_sink_inst (.clk(clk), .rst(rst), .duty(lf[7:5]),
        .ready(word_ready));
    word_sink word_sink_lib_inst (.clk(clk), .rst(rst), .duty(3'h5),
        .ready(lib_ready));
    task automatic chk_bit(input string what, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %0d seen %0d", what, e, g);
        end
    endtask : chk_bit
    task automatic chk_num(input string what, input logic [31:0] e,
                           input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %0d seen %0d", what, e, g);
        end
    endtask : chk_num
    task automatic give_verdict;
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // raw source: mode 0 balanced pairs, 1 stuck high, 2 biased
    // ----------------------------------------------------------------
    initial begin
        forever begin
            @(posedge clk);
            #1;
            lf = lfsr_next(lf);
            raw_valid = lf[0] | lf[1];
            if (raw_valid) begin
                pc++;
                if (mode == 1) raw_bit = 1'b1;
                else if (mode == 2) raw_bit = (pc % 8 != 0);
                else raw_bit = pc[0] ? lf[2] : ~raw_bit;
            end
        end
    end
    // reference: good windows counted from the raw stream
    always @(posedge clk) begin
        if (rst) begin
            ones = 0;
            nb = 0;
            good = 0;
            mrun = 0;
            mprev = 1'b0;
            mfail = 1'b0;
        end else begin
            chk_bit("fail_sticky", mfail, fail_sticky);
            if ((word_valid || lib_valid) && (good < 2 || mfail))
                chk_bit("out_gate", 1'b0, word_valid || lib_valid);
            if (word_valid && word_ready) dw++;
            if (word_valid && word_ready && narrow)
                chk_num("word_hi", 0, {24'h000000, word_data[15:8]});
            if (lib_valid && lib_ready) begin
                lw++;
                if (lib_word.last) last_at = lw;
            end
            if (req_error) err_seen = 1'b1;
            if (raw_valid) begin
                // run of eight equal bits is the bench's total failure
                mrun = (raw_bit == mprev) ? mrun + 1 : 1;
                mprev = raw_bit;
                if (mrun >= 8) mfail = 1'b1;
                ones += raw_bit;
                nb++;
                if (nb == 16) begin
                    if (ones >= 4 && ones <= 12) good++;
                    else mfail = 1'b1;
                    ones = 0;
                    nb = 0;
                end
            end
        end
    end
    task automatic do_reset;
        #1 rst = 1'b1;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
    endtask : do_reset
    task automatic wait_healthy;
        int i;
        // healthy is read between edges, after the raw inputs settle
        for (i = 0; i < 300 && healthy !== 1'b1; i++) begin
            @(posedge clk);
            #2;
        end
        chk_bit("healthy", 1'b1, healthy);
        chk_bit("fail_sticky", 1'b0, fail_sticky);
    endtask : wait_healthy
    task automatic lib_req(input logic [32:0] n, input logic bad);
        int i;
        i = 0;
        @(posedge clk);
        #1;
        err_seen = 1'b0;
        lw = 0;
        last_at = -1;
        req.wide = 1'b1;
        req.nbytes = n;
        req_valid = 1'b1;
        // req_ready is read between edges, where it is settled
        while (req_ready !== 1'b1 && i < 400) begin
            @(posedge clk);
            #1;
            i++;
        end
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        for (i = 0; i < 600 && req_ready !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        #1;
        chk_bit("req_error", bad, err_seen);
        chk_num("lib_words", bad ? 0 : int'(n[31:0] >> 1), lw);
        if (!bad && n != 0)
            chk_num("lib_last", int'(n[31:0] >> 1), last_at);
    endtask : lib_req
    initial begin
        rst = 1'b1;
        {raw_bit, raw_valid, req_valid, narrow, err_seen} = 5'h00;
        word_wide = 1'b1;
        req = '0;
        lf = 8'h54;
        {dw, pc, lw} = 0;
        do_reset;
        wait_healthy;
        repeat (60) @(posedge clk);
        chk_bit("words_flow", 1'b1, dw > 0);
        #1 word_wide = 1'b0;
        repeat (80) @(posedge clk);
        #1 narrow = 1'b1;
        repeat (60) @(posedge clk);
        lib_req(33'h8, 1'b0);
        lib_req(33'h0, 1'b0);
        lib_req(33'h4, 1'b0);
        lib_req(33'h6, 1'b1);
        lib_req(33'h2, 1'b1);
        lib_req(33'h100000004, 1'b1);
        mode = 2;
        repeat (60) @(posedge clk);
        #2 chk_bit("fail_sticky", 1'b1, fail_sticky);
        chk_bit("healthy", 1'b0, healthy);
        mode = 0;
        repeat (60) @(posedge clk);
        #2 chk_bit("sticky_hold", 1'b1, fail_sticky);
        mode = 1;
        do_reset;
        repeat (30) @(posedge clk);
        #2 chk_bit("fail_sticky", 1'b1, fail_sticky);
        chk_bit("healthy", 1'b0, healthy);
        mode = 0;
        do_reset;
        wait_healthy;
        mode = 1;
        repeat (20) @(posedge clk);
        #2 chk_bit("fail_sticky", 1'b1, fail_sticky);
        chk_bit("healthy", 1'b0, healthy);
        give_verdict;
    end
    // the whole sequence needs well under ten thousand cycles
    initial begin
        #(40 * 20000);
        errors++;
        give_verdict;
    end
endmodule : tb_trng_health_gated_output
